// >>> core/rstwd_pkg.sv
// Shared constants for the reset sequencer and watchdog block.
package rstwd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB side.
  localparam logic [15:0] RSTWD_ADDR_WDOG_LOC = 16'h3FF0;
  localparam logic [15:0] RSTWD_ADDR_STATUS = 16'h3FF4;
  localparam logic [31:0] RSTWD_RDATA_ZERO = 32'h0000_0000;
  localparam int RSTWD_WDOG_CLR_BIT = 0;

  // Status register field positions.
  localparam int RSTWD_ST_INT_RESET = 0;
  localparam int RSTWD_ST_LOW_POWER = 1;
  localparam int RSTWD_ST_EXT_PIN = 2;
  localparam int RSTWD_ST_WDOG_RST = 3;
  localparam int RSTWD_ST_ILLEGAL = 4;
  localparam int RSTWD_ST_STAB_BUSY = 5;
  localparam int RSTWD_ST_NONUSER = 6;
  localparam int RSTWD_ST_STOP_HOLD = 7;
  localparam int RSTWD_ST_WD_CNT_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Stabilisation delay in bus clock cycles.
  localparam int RSTWD_STAB_CYCLES = 4064;
  localparam logic [11:0] RSTWD_STAB_LAST = 12'(RSTWD_STAB_CYCLES - 1);
  localparam logic [11:0] RSTWD_STAB_RST = 12'h000;

  // Watchdog: prescale by eight, then a fixed timeout in prescaled ticks.
  localparam logic [2:0] RSTWD_PRESC_LAST = 3'h7;
  localparam logic [2:0] RSTWD_PRESC_RST = 3'h0;
  localparam logic [7:0] RSTWD_WD_LAST = 8'hFF;
  localparam logic [7:0] RSTWD_WD_RST = 8'h00;

  // Length of the internal reset raised by watchdog or illegal fetch.
  localparam logic [3:0] RSTWD_PULSE_LAST = 4'h7;
  localparam logic [3:0] RSTWD_PULSE_RST = 4'h0;

  // Highest peripheral address that must never hold code; the range starts at address zero.
  localparam logic [15:0] RSTWD_ILLEGAL_LAST = 16'h001F;

endpackage : rstwd_pkg

// >>> core/rstwd_sync.sv
// Two-flop synchroniser for the three asynchronous input pins.
`timescale 1ns/100ps
module rstwd_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);

  logic [2:0] meta_r;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pins come up at their idle high level and the mode request at zero,
  // so no false reset or mode request shows at power-up.
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= 3'h3;
      sync_out <= 3'h3;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // rstwd_sync

// >>> core/rstwd_top.sv
// Reset sources, stabilisation delay, watchdog and mode selection.
// Behaviour
// - Low-power pin low asserts internal reset and halts clocks and oscillator.
// - Reset and clock halt last as long as the low-power pin is low.
// - After the pin rises, clocks restart and reset holds 4064 more cycles.
// - If another source is active at count end, reset stays until it ends.
// - Only pin or watchdog reset end sets nonuser mode; illegal keeps mode.
// - Power-on holds reset 4064 cycles from oscillator start.
// - Power-on reset reacts only to power turn-on, not to supply drops.
// - Watchdog timeout without a clear resets the whole controller.
// - A build option fixes watchdog presence; present means active always.
// - Writing zero to bit 0 of the watchdog location restarts the count.
// - Reading the watchdog location returns user data, not watchdog state.
// - Watchdog keeps counting in wait mode; software must clear it.
// - Stop clears the watchdog and holds it cleared until stop ends.
// - Reset leaving stop holds the watchdog until stabilisation completes.
// - Interrupt leaving stop lets the watchdog count at once.
// - Opcode fetch from the peripheral range raises an illegal-address reset.
// - The internal reset resets every peripheral module.
// - Watchdog ticks are the periodic divider output divided by eight.
`timescale 1ns/100ps
module rstwd_top #(
  parameter bit WDOG_PRESENT = 1'b1
) (
  // Clock and power-on reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Reset and mode pins
  input wire logic LOW_POWER_RESET_PIN_N,
  input wire logic EXT_RESET_PIN_N,
  input wire logic MODE_SELECT_PIN,
  // CPU core status
  input wire logic FETCH_VALID,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic STOP_ACTIVE,
  input wire logic [7:0] USER_VECTOR_BYTE,
  // Periodic interrupt divider output, one-cycle pulse
  input wire logic PERIODIC_TICK,
  // Reset and clock control outputs
  output logic INT_RESET,
  output logic CLK_HALT,
  output logic NONUSER_MODE
);
  import rstwd_pkg::*;

  logic [2:0] pins_s;
  logic lp_low;
  logic ext_low;
  logic mode_pin;
  logic ext_low_d_r;
  logic [11:0] stab_cnt_r;
  logic stab_busy_r;
  logic stop_at_rst_r;
  logic [2:0] presc_r;
  logic [7:0] wd_cnt_r;
  logic wd_fire;
  logic wd_clear;
  logic ill_fire;
  logic src_wdog_r;
  logic src_ill_r;
  logic [3:0] pulse_r;
  logic reset_nxt;
  logic apb_setup;
  logic apb_write;
  logic [31:0] status_word;

  function automatic logic addr_is(input logic [15:0] a,
                                   input logic [15:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The clock halt follows the synchronised level, so it
  // needs a few running edges to take effect; the pad logic must keep the
  // oscillator alive until CLK_HALT rises.
  rstwd_sync u_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .async_in({MODE_SELECT_PIN, EXT_RESET_PIN_N, LOW_POWER_RESET_PIN_N}),
    .sync_out(pins_s)
  );

  assign lp_low = ~pins_s[0];
  assign ext_low = ~pins_s[1];
  assign mode_pin = pins_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // Stabilisation counter. SRST stands for supply turn-on only; a supply drop
  // without SRST is not seen here.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      stab_cnt_r <= RSTWD_STAB_RST;
      stab_busy_r <= 1'b1;
    end else if (lp_low || (ext_low && stop_at_rst_r)) begin
      stab_cnt_r <= RSTWD_STAB_RST;
      stab_busy_r <= 1'b1;
    end else if (stab_busy_r) begin
      if (stab_cnt_r == RSTWD_STAB_LAST) begin
        stab_busy_r <= 1'b0;
      end else begin
        stab_cnt_r <= stab_cnt_r + 12'h001;
      end
    end
  end

  // Remembers that a pin reset arrived while the CPU was stopped.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      stop_at_rst_r <= 1'b0;
    end else if (ext_low && STOP_ACTIVE) begin
      stop_at_rst_r <= 1'b1;
    end else if (!ext_low && !stab_busy_r) begin
      stop_at_rst_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog. Clearing on internal reset also keeps it held through the
  // stabilisation count after a reset; a plain stop exit releases it at once.
  assign wd_clear = apb_write && addr_is(PADDR, RSTWD_ADDR_WDOG_LOC) &&
                    !PWDATA[RSTWD_WDOG_CLR_BIT];
  assign wd_fire = WDOG_PRESENT && PERIODIC_TICK &&
                   (presc_r == RSTWD_PRESC_LAST) &&
                   (wd_cnt_r == RSTWD_WD_LAST);

  always_ff @(posedge REF_CLK) begin
    if (SRST || INT_RESET || STOP_ACTIVE) begin
      presc_r <= RSTWD_PRESC_RST;
      wd_cnt_r <= RSTWD_WD_RST;
    end else if (wd_clear) begin
      presc_r <= RSTWD_PRESC_RST;
      wd_cnt_r <= RSTWD_WD_RST;
    end else if (WDOG_PRESENT && PERIODIC_TICK) begin
      presc_r <= presc_r + 3'h1;
      if (presc_r == RSTWD_PRESC_LAST) begin
        wd_cnt_r <= wd_cnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Illegal fetch and watchdog sources, each stretched to a short pulse.
  assign ill_fire = FETCH_VALID && !INT_RESET &&
                    (FETCH_ADDR <= RSTWD_ILLEGAL_LAST);

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      src_wdog_r <= 1'b0;
      src_ill_r <= 1'b0;
      pulse_r <= RSTWD_PULSE_RST;
    end else if (wd_fire || ill_fire) begin
      src_wdog_r <= src_wdog_r | wd_fire;
      src_ill_r <= src_ill_r | ill_fire;
      pulse_r <= RSTWD_PULSE_RST;
    end else if (src_wdog_r || src_ill_r) begin
      pulse_r <= pulse_r + 4'h1;
      if (pulse_r == RSTWD_PULSE_LAST) begin
        src_wdog_r <= 1'b0;
        src_ill_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal reset and clock halt.
  assign reset_nxt = lp_low || ext_low || stab_busy_r || src_wdog_r ||
                     src_ill_r;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      INT_RESET <= 1'b1;
      CLK_HALT <= 1'b0;
    end else begin
      INT_RESET <= reset_nxt;
      CLK_HALT <= lp_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode, decided when a reset source ends.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ext_low_d_r <= 1'b0;
      NONUSER_MODE <= 1'b0;
    end else begin
      ext_low_d_r <= ext_low;
      if (lp_low) begin
        NONUSER_MODE <= 1'b0;
      end else if ((ext_low_d_r && !ext_low) ||
                   (src_wdog_r && pulse_r == RSTWD_PULSE_LAST)) begin
        NONUSER_MODE <= mode_pin;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access, ready raised by the setup cycle.
  assign apb_setup = PSEL && !PENABLE;
  assign apb_write = PSEL && PENABLE && PREADY && PWRITE;

  always_comb begin
    status_word = RSTWD_RDATA_ZERO;
    status_word[RSTWD_ST_INT_RESET] = INT_RESET;
    status_word[RSTWD_ST_LOW_POWER] = lp_low;
    status_word[RSTWD_ST_EXT_PIN] = ext_low;
    status_word[RSTWD_ST_WDOG_RST] = src_wdog_r;
    status_word[RSTWD_ST_ILLEGAL] = src_ill_r;
    status_word[RSTWD_ST_STAB_BUSY] = stab_busy_r;
    status_word[RSTWD_ST_NONUSER] = NONUSER_MODE;
    status_word[RSTWD_ST_STOP_HOLD] = STOP_ACTIVE;
    status_word[RSTWD_ST_WD_CNT_LSB +: 8] = wd_cnt_r;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= RSTWD_RDATA_ZERO;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup &&
                 !addr_is(PADDR, RSTWD_ADDR_WDOG_LOC) &&
                 !addr_is(PADDR, RSTWD_ADDR_STATUS);
      if (apb_setup && !PWRITE &&
          addr_is(PADDR, RSTWD_ADDR_WDOG_LOC)) begin
        PRDATA <= {24'h000000, USER_VECTOR_BYTE};
      end else if (apb_setup && !PWRITE &&
                   addr_is(PADDR, RSTWD_ADDR_STATUS)) begin
        PRDATA <= status_word;
      end else if (apb_setup) begin
        PRDATA <= RSTWD_RDATA_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  a_lp_holds_reset: assert property (
    lp_low |=> INT_RESET && CLK_HALT)
    else $error("low-power pin low without reset and clock halt");

  a_lp_stab_hold: assert property (
    $fell(lp_low) |-> ##1 INT_RESET [*8])
    else $error("reset released too soon after low-power pin rise");

  a_stab_len: assert property (
    stab_busy_r && stab_cnt_r != RSTWD_STAB_LAST |=> stab_busy_r)
    else $error("stabilisation count ended early");

  a_stab_step: assert property (
    stab_busy_r && !lp_low && !(ext_low && stop_at_rst_r) &&
      stab_cnt_r != RSTWD_STAB_LAST
      |=> stab_busy_r && stab_cnt_r == $past(stab_cnt_r) + 12'h001)
    else $error("stabilisation count skipped a cycle");

  a_src_or: assert property (
    (src_wdog_r || src_ill_r || ext_low) |=> INT_RESET)
    else $error("active source did not hold internal reset");

  a_wd_reset: assert property (
    wd_fire |=> src_wdog_r ##1 INT_RESET)
    else $error("watchdog timeout did not raise reset");

  a_wd_clear_write: assert property (
    wd_clear |=> wd_cnt_r == RSTWD_WD_RST && presc_r == RSTWD_PRESC_RST)
    else $error("watchdog clear write did not restart count");

  a_stop_hold: assert property (
    STOP_ACTIVE |=> wd_cnt_r == RSTWD_WD_RST)
    else $error("watchdog counted during stop");

  a_illegal_fetch: assert property (
    ill_fire |=> src_ill_r ##1 INT_RESET)
    else $error("illegal fetch did not raise reset");

  a_lp_user_mode: assert property (
    lp_low |=> !NONUSER_MODE)
    else $error("low-power reset left nonuser mode");

  a_ill_keeps_mode: assert property (
    src_ill_r && !src_wdog_r && !ext_low && !ext_low_d_r && !lp_low
      |=> $stable(NONUSER_MODE))
    else $error("illegal-address reset changed mode");

  a_wd_read_user: assert property (
    apb_setup && !PWRITE && addr_is(PADDR, RSTWD_ADDR_WDOG_LOC)
      |=> PRDATA == {24'h000000, $past(USER_VECTOR_BYTE)})
    else $error("watchdog location read returned wrong data");

  a_presc_eight: assert property (
    PERIODIC_TICK && presc_r != RSTWD_PRESC_LAST && !wd_clear &&
      !INT_RESET && !STOP_ACTIVE |=> $stable(wd_cnt_r))
    else $error("watchdog advanced before eighth tick");

  a_wd_advance: assert property (
    WDOG_PRESENT && PERIODIC_TICK && presc_r == RSTWD_PRESC_LAST &&
      !wd_clear && !INT_RESET && !STOP_ACTIVE
      |=> wd_cnt_r == $past(wd_cnt_r) + 8'h01)
    else $error("watchdog missed its eighth tick");

  a_halt_release: assert property (
    !lp_low |=> !CLK_HALT)
    else $error("clock halt kept after low-power pin rose");

  a_release_all: assert property (
    !reset_nxt |=> !INT_RESET)
    else $error("internal reset held with no active source");

  a_ext_mode: assert property (
    ext_low_d_r && !ext_low && !lp_low |=> NONUSER_MODE == $past(mode_pin))
    else $error("pin reset end did not take requested mode");

  a_stop_rst_hold: assert property (
    stop_at_rst_r && stab_busy_r
      |=> wd_cnt_r == RSTWD_WD_RST && presc_r == RSTWD_PRESC_RST)
    else $error("watchdog ran during stabilisation after stop");

  a_ill_len: assert property (
    $rose(src_ill_r) |-> src_ill_r [*8])
    else $error("illegal-address reset source too short");

  a_ill_blocked: assert property (
    FETCH_VALID && FETCH_ADDR > RSTWD_ILLEGAL_LAST && !src_ill_r
      |=> !src_ill_r)
    else $error("fetch outside peripheral range raised reset");

endmodule // rstwd_top

// >>> tb/rstwd_tick_model.sv
// Periodic divider model that feeds ticks to the watchdog prescaler.
`timescale 1ns/100ps
module rstwd_tick_model #(
  parameter int DIV = 2
) (
  // Clock and control
  input wire logic clk,
  input wire logic enable,
  // One-cycle tick out
  output logic tick
);
  int cnt;

  ////////////////////////////////////////////////////////////////////////////
  // A tick every DIV cycles keeps watchdog timeouts short enough to simulate.
  always_ff @(posedge clk) begin
    if (!enable) begin
      cnt <= 0;
      tick <= 1'b0;
    end else if (cnt == DIV - 1) begin
      cnt <= 0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      tick <= 1'b0;
    end
  end
endmodule // rstwd_tick_model

// >>> tb/tb_top.sv
// Self-checking testbench for the reset sequencer and watchdog.
`timescale 1ns/100ps
module tb_top;
  import rstwd_pkg::*;
  logic clk, srst, psel, penable, pwrite, lp_n, ext_n, mode_sel, serr;
  logic fetch_v, stop_act, tick_en, tick, prdy, perr, int_rst, halt, nonuser;
  logic [15:0] paddr, fetch_a;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] user_byte;
  logic int_rst2;
  int err_total, compares, n, t0, cycle_no;

  rstwd_top i_rstwd_top (.REF_CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr),
    .LOW_POWER_RESET_PIN_N(lp_n), .EXT_RESET_PIN_N(ext_n),
    .MODE_SELECT_PIN(mode_sel), .FETCH_VALID(fetch_v), .FETCH_ADDR(fetch_a),
    .STOP_ACTIVE(stop_act), .USER_VECTOR_BYTE(user_byte),
    .PERIODIC_TICK(tick), .INT_RESET(int_rst), .CLK_HALT(halt),
    .NONUSER_MODE(nonuser));
  // Same block built without a watchdog; long waits must never reset it.
  rstwd_top #(.WDOG_PRESENT(1'b0)) i_rstwd_top_nowd (.REF_CLK(clk),
    .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR(),
    .LOW_POWER_RESET_PIN_N(lp_n), .EXT_RESET_PIN_N(ext_n),
    .MODE_SELECT_PIN(mode_sel), .FETCH_VALID(fetch_v), .FETCH_ADDR(fetch_a),
    .STOP_ACTIVE(stop_act), .USER_VECTOR_BYTE(user_byte),
    .PERIODIC_TICK(tick), .INT_RESET(int_rst2), .CLK_HALT(),
    .NONUSER_MODE());
  rstwd_tick_model i_rstwd_tick_model (.clk(clk), .enable(tick_en),
    .tick(tick));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cycle_no <= cycle_no + 1;

  ////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, s, seen,
        exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // A limit that runs out ends the run at once with a failure.
  task wait_rst(input logic lvl, input int lim);
    n = 0;
    while (int_rst !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        chk(int_rst, lvl, "reset wait limit");
        print_verdict();
      end
    end
  endtask

  task quiet(input int k);
    int hits;
    hits = 0;
    repeat (k) begin
      @(posedge clk);
      if (int_rst !== 1'b0) hits++;
    end
    chk(hits, 0, "unexpected internal reset");
  endtask

  task in_range(input int v, input int lo, input int hi, input string s);
    chk(32'(v >= lo && v <= hi), 32'h1, s);
  endtask

  // One APB transfer; the request stands until PREADY is sampled high.
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    rd = prdata;
    serr = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (prdy !== 1'b1) begin
      chk(prdy, 1'b1, "bus wait limit");
      print_verdict();
    end
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_power_on;
    wait_rst(1'b0, 5000);
    in_range(n, 4060, 4072, "power-on hold");
    chk(nonuser, 1'b0, "mode after power-on");
  endtask

  task t_regs;
    apb(1'b0, RSTWD_ADDR_WDOG_LOC, 32'h0);
    chk(rd, {24'h000000, user_byte}, "vector byte read");
    apb(1'b0, 16'h0100, 32'h0);
    chk(serr, 1'b1, "unmapped error");
    apb(1'b0, RSTWD_ADDR_STATUS, 32'h0);
    chk(rd[RSTWD_ST_INT_RESET], 1'b0, "status reset bit");
  endtask

  // Zero writes restart the count; a write of one must not.
  task t_watchdog;
    tick_en <= 1'b1;
    mode_sel <= 1'b1;
    repeat (3) begin
      quiet(3000);
      apb(1'b1, RSTWD_ADDR_WDOG_LOC, 32'h0);
    end
    t0 = cycle_no;
    quiet(2000);
    apb(1'b1, RSTWD_ADDR_WDOG_LOC, 32'h1);
    wait_rst(1'b1, 3000);
    in_range(cycle_no - t0, 4088, 4108, "watchdog timeout");
    chk(int_rst2, 1'b0, "reset without watchdog");
    wait_rst(1'b0, 100);
    chk(nonuser, 1'b1, "mode after watchdog");
  endtask

  task t_illegal;
    mode_sel <= 1'b0;
    fetch_a <= 16'h0020;
    fetch_v <= 1'b1;
    cyc(1);
    fetch_v <= 1'b0;
    quiet(10);
    fetch_a <= RSTWD_ILLEGAL_LAST;
    fetch_v <= 1'b1;
    cyc(1);
    fetch_v <= 1'b0;
    wait_rst(1'b1, 5);
    wait_rst(1'b0, 50);
    chk(nonuser, 1'b1, "mode after illegal");
  endtask

  task t_low_power;
    lp_n <= 1'b0;
    cyc(4);
    chk(halt, 1'b1, "halt on pin");
    chk(int_rst, 1'b1, "reset on pin");
    cyc(50);
    chk({halt, int_rst}, 2'b11, "held while low");
    chk(nonuser, 1'b0, "user mode forced");
    lp_n <= 1'b1;
    cyc(6);
    chk(halt, 1'b0, "clocks restart");
    cyc(3990);
    chk(int_rst, 1'b1, "stabilisation hold");
    ext_n <= 1'b0;
    cyc(300);
    chk(int_rst, 1'b1, "other source holds");
    ext_n <= 1'b1;
    wait_rst(1'b0, 10);
  endtask

  // Leaving stop by interrupt counts at once; by reset, only after the hold.
  task t_stop;
    stop_act <= 1'b1;
    quiet(5000);
    stop_act <= 1'b0;
    t0 = cycle_no;
    wait_rst(1'b1, 5000);
    in_range(cycle_no - t0, 4088, 4108, "interrupt exit");
    wait_rst(1'b0, 100);
    stop_act <= 1'b1;
    mode_sel <= 1'b1;
    cyc(10);
    ext_n <= 1'b0;
    cyc(10);
    ext_n <= 1'b1;
    wait_rst(1'b0, 5000);
    in_range(n, 4040, 4090, "stop reset hold");
    stop_act <= 1'b0;
    t0 = cycle_no;
    wait_rst(1'b1, 5000);
    in_range(cycle_no - t0, 4088, 4108, "reset exit");
    chk(nonuser, 1'b1, "mode after pin reset");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    lp_n = 1'b1;
    ext_n = 1'b1;
    mode_sel = 1'b0;
    fetch_v = 1'b0;
    fetch_a = 16'h0000;
    stop_act = 1'b0;
    tick_en = 1'b0;
    user_byte = 8'hA5;
    err_total = 0;
    compares = 0;
    cyc(5);
    srst <= 1'b0;
    t_power_on();
    t_regs();
    t_watchdog();
    t_illegal();
    t_low_power();
    t_stop();
    print_verdict();
  end
endmodule // tb_top
